// [core/flash_lock_pkg.sv]
// constants, register map and types of the flash lock controller
// What this block does
// - host masks reserved status bit 0 when polling.
// - host checks ready bit before interpreting failure bits.
// - host locks a block with 60H then 01H at the block address.
// - host unlocks with 60H then D0H; locked-down blocks stay locked if pin low.
// - host locks down with 60H then 2FH; device sets the lock-down bit.
package flash_lock_pkg;
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned DQ_W   = 16;

  // flash command codes
  localparam logic [7:0] CMD_SETUP   = 8'h60;
  localparam logic [7:0] CMD_LOCK    = 8'h01;
  localparam logic [7:0] CMD_UNLOCK  = 8'hD0;
  localparam logic [7:0] CMD_LOCKDN  = 8'h2F;
  localparam logic [7:0] CMD_CLEAR   = 8'h50;
  localparam logic [7:0] CMD_RDSTAT  = 8'h70;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME  = 8'hD0;
  localparam logic [7:0] CMD_ARRAY   = 8'hFF;

  // status bit positions
  localparam int unsigned STAT_READY  = 7;
  localparam int unsigned STAT_ESUSP  = 6;
  localparam int unsigned STAT_EFAIL  = 5;
  localparam int unsigned STAT_PFAIL  = 4;
  localparam int unsigned STAT_VPPLOW = 3;
  localparam int unsigned STAT_PSUSP  = 2;
  localparam int unsigned STAT_LOCKV  = 1;
  localparam int unsigned STAT_RSVD   = 0;
  localparam logic [7:0]  STAT_MASK   = 8'hFE;

  // apb register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PINS   = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int unsigned PINS_WP   = 0;
  localparam int unsigned PINS_RST  = 1;
  localparam int unsigned ST_BUSY   = 8;
  localparam int unsigned ST_SEQERR = 9;
  localparam int unsigned ST_LOCKV  = 10;
  localparam int unsigned ST_PFAIL  = 11;
  localparam int unsigned ST_EFAIL  = 12;
  localparam int unsigned ST_VPP    = 13;
  localparam int unsigned ST_SUSP   = 14;

  // flash bus phase time
  localparam int unsigned CLK_NS    = 5;
  localparam int unsigned PHASE_NS  = 50;
  localparam int unsigned PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PHASE_W   = $clog2(PHASE_CYC + 1);

  typedef enum logic [2:0] {
    OP_LOCK, OP_UNLOCK, OP_LOCKDOWN, OP_CLEAR,
    OP_READ, OP_SUSPEND, OP_RESUME, OP_BADSEQ
  } op_t;
endpackage

// [core/flash_cycle_if.sv]
// request/answer carrier between sequencer and flash bus cycle engine
`timescale 1ns/10ps
interface flash_cycle_if;
  import flash_lock_pkg::*;
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   wdata;
  logic              ack;
  logic [DQ_W-1:0]   rdata;
  modport seq (output req, wr, addr, wdata, input ack, rdata);
  modport eng (input req, wr, addr, wdata, output ack, rdata);
endinterface

// [core/flash_cycle_engine.sv]
// one asynchronous flash bus read or write cycle per request
`timescale 1ns/10ps
module flash_cycle_engine
  import flash_lock_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // request side
  flash_cycle_if.eng             cyc,
  // flash pins
  output logic [ADDR_W-1:0]      fl_addr,
  input  wire logic [DQ_W-1:0]   fl_dq_in,
  output logic [DQ_W-1:0]        fl_dq_out,
  output logic                   fl_dq_oe_n,
  output logic                   fl_ce_n,
  output logic                   fl_we_n,
  output logic                   fl_oe_n
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_t;
  eng_t               st_q;
  logic [PHASE_W-1:0] cnt_q;
  logic               tick;
  logic               wr_q;

  // phase divider restarts per cycle so every phase is full length
  assign tick    = (cnt_q == PHASE_W'(PHASE_CYC - 1));
  assign cyc.ack = (st_q == E_HOLD) && tick;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= '0;
    else if (st_q == E_IDLE || tick)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + PHASE_W'(1);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st_q       <= E_IDLE;
      wr_q       <= 1'b0;
      fl_addr    <= '0;
      fl_dq_out  <= '0;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n    <= 1'b1;
      fl_we_n    <= 1'b1;
      fl_oe_n    <= 1'b1;
      cyc.rdata  <= '0;
    end
    else
    begin
      case (st_q)
        E_IDLE:
          if (cyc.req)
          begin
            st_q       <= E_SETUP;
            wr_q       <= cyc.wr;
            fl_addr    <= cyc.addr;
            fl_dq_out  <= cyc.wdata;
            fl_dq_oe_n <= !cyc.wr;
            fl_ce_n    <= 1'b0;
          end
        E_SETUP:
          if (tick)
          begin
            st_q    <= E_STROBE;
            fl_we_n <= !wr_q;
            fl_oe_n <= wr_q;
          end
        E_STROBE:
          if (tick)
          begin
            st_q    <= E_HOLD;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            if (!wr_q)
              cyc.rdata <= fl_dq_in;
          end
        E_HOLD:
          if (tick)
          begin
            st_q       <= E_IDLE;
            fl_ce_n    <= 1'b1;
            fl_dq_oe_n <= 1'b1;
          end
        default:
          st_q <= E_IDLE;
      endcase
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strobe_excl_a: assert property (!(!fl_we_n && !fl_oe_n))
    else $error("write and output enable strobes low together");
  strobe_chip_a: assert property ((!fl_we_n || !fl_oe_n) |-> !fl_ce_n)
    else $error("strobe without chip enable");
  drive_read_a: assert property (!fl_oe_n |-> fl_dq_oe_n)
    else $error("data driven during read strobe");
endmodule

// [core/flash_lock_host.sv]
// apb controlled host that locks, unlocks and polls a parallel nor flash
`timescale 1ns/10ps
module flash_lock_host
  import flash_lock_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // flash pins
  output logic [ADDR_W-1:0]      fl_addr,
  input  wire logic [DQ_W-1:0]   fl_dq_in,
  output logic [DQ_W-1:0]        fl_dq_out,
  output logic                   fl_dq_oe_n,
  output logic                   fl_ce_n,
  output logic                   fl_we_n,
  output logic                   fl_oe_n,
  output logic                   fl_wp,
  output logic                   fl_rst_n
);
  typedef enum logic [2:0] {
    S_IDLE, S_CMD1, S_CMD2, S_SRCMD, S_SRRD
  } seq_t;

  flash_cycle_if cyc ();

  seq_t              st_q;
  op_t               op_q;
  logic [ADDR_W-1:0] blk_q;
  logic              wp_q;
  logic              frst_q;
  logic [7:0]        stat_q;
  logic              wr_acc;
  logic              rd_set;
  logic              start;
  logic              stat_ready;
  logic [7:0]        cmd2;
  logic [31:0]       rd_d;
  logic              hit;

  // zero wait state slave
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_set = psel && !penable;
  assign hit    = (paddr == REG_CTRL) || (paddr == REG_PINS) ||
                  (paddr == REG_ADDR) || (paddr == REG_STATUS);
  // a new operation is refused while one is running
  assign start  = wr_acc && (paddr == REG_CTRL) && (st_q == S_IDLE);
  assign stat_ready = cyc.rdata[STAT_READY];
  assign fl_wp    = wp_q;
  assign fl_rst_n = !frst_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wp_q   <= 1'b0;
      frst_q <= 1'b0;
      blk_q  <= '0;
    end
    else if (wr_acc)
    begin
      if (paddr == REG_PINS)
      begin
        wp_q   <= pwdata[PINS_WP];
        frst_q <= pwdata[PINS_RST];
      end
      if (paddr == REG_ADDR)
        blk_q <= pwdata[ADDR_W-1:0];
    end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (paddr)
      REG_CTRL:   rd_d[2:0] = op_q;
      REG_PINS:
      begin
        rd_d[PINS_WP]  = wp_q;
        rd_d[PINS_RST] = frst_q;
      end
      REG_ADDR:   rd_d[ADDR_W-1:0] = blk_q;
      REG_STATUS:
      begin
        rd_d[7:0]       = stat_q;
        rd_d[ST_BUSY]   = (st_q != S_IDLE);
        rd_d[ST_SEQERR] = stat_q[STAT_PFAIL] && stat_q[STAT_EFAIL];
        rd_d[ST_LOCKV]  = stat_q[STAT_LOCKV];
        rd_d[ST_PFAIL]  = stat_q[STAT_PFAIL] && !stat_q[STAT_EFAIL];
        rd_d[ST_EFAIL]  = stat_q[STAT_EFAIL] && !stat_q[STAT_PFAIL];
        rd_d[ST_VPP]    = stat_q[STAT_VPPLOW];
        rd_d[ST_SUSP]   = stat_q[STAT_ESUSP] || stat_q[STAT_PSUSP];
      end
      default:    rd_d = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup cycle so it is steady in access
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (rd_set)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= !hit;
    end

  // second code of the configuration pair
  always_comb
    case (op_q)
      OP_LOCK:     cmd2 = CMD_LOCK;
      OP_UNLOCK:   cmd2 = CMD_UNLOCK;
      OP_LOCKDOWN: cmd2 = CMD_LOCKDN;
      default:     cmd2 = CMD_ARRAY;
    endcase

  always_comb
  begin
    cyc.req   = (st_q != S_IDLE);
    cyc.wr    = (st_q != S_SRRD);
    cyc.addr  = blk_q;
    cyc.wdata = '0;
    case (st_q)
      S_CMD1:
        case (op_q)
          OP_CLEAR:   cyc.wdata[7:0] = CMD_CLEAR;
          OP_SUSPEND: cyc.wdata[7:0] = CMD_SUSPEND;
          OP_RESUME:  cyc.wdata[7:0] = CMD_RESUME;
          default:    cyc.wdata[7:0] = CMD_SETUP;
        endcase
      S_CMD2:  cyc.wdata[7:0] = cmd2;
      S_SRCMD: cyc.wdata[7:0] = CMD_RDSTAT;
      default: cyc.wdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st_q <= S_IDLE;
      op_q <= OP_READ;
    end
    else
    begin
      case (st_q)
        S_IDLE:
          if (start)
          begin
            op_q <= op_t'(pwdata[2:0]);
            st_q <= (op_t'(pwdata[2:0]) == OP_READ) ? S_SRCMD : S_CMD1;
          end
        S_CMD1:
          if (cyc.ack)
            case (op_q)
              OP_CLEAR, OP_SUSPEND: st_q <= S_SRCMD;
              // a resumed operation keeps the device busy; no polling
              OP_RESUME:            st_q <= S_IDLE;
              default:              st_q <= S_CMD2;
            endcase
        S_CMD2:
          if (cyc.ack)
            st_q <= S_SRCMD;
        S_SRCMD:
          if (cyc.ack)
            st_q <= S_SRRD;
        S_SRRD:
          if (cyc.ack && stat_ready)
            st_q <= S_IDLE;
        default:
          st_q <= S_IDLE;
      endcase
    end

  // status is kept only once the state machine reports ready
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stat_q <= 8'h00;
    else if (st_q == S_SRRD && cyc.ack && stat_ready)
      stat_q <= cyc.rdata[7:0] & STAT_MASK;

  flash_cycle_engine u_eng (
    .pclk       (pclk),
    .presetn    (presetn),
    .cyc        (cyc),
    .fl_addr    (fl_addr),
    .fl_dq_in   (fl_dq_in),
    .fl_dq_out  (fl_dq_out),
    .fl_dq_oe_n (fl_dq_oe_n),
    .fl_ce_n    (fl_ce_n),
    .fl_we_n    (fl_we_n),
    .fl_oe_n    (fl_oe_n)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reserved_masked_a: assert property (!stat_q[STAT_RSVD])
    else $error("reserved status bit kept");
  ready_before_use_a: assert property (
    $changed(stat_q) |-> stat_q[STAT_READY])
    else $error("status kept while state machine busy");
  // only the first cycle of the second code still sees the setup code
  lock_pair_a: assert property (
    (st_q == S_CMD2 && $past(st_q) == S_CMD1 && op_q == OP_LOCK) |->
      cyc.wdata[7:0] == CMD_LOCK && $past(cyc.wdata[7:0]) == CMD_SETUP)
    else $error("lock code not preceded by setup");
  unlock_pair_a: assert property (
    (st_q == S_CMD2 && op_q == OP_UNLOCK) |-> cyc.wdata[7:0] == CMD_UNLOCK)
    else $error("wrong unlock code");
  lockdown_pair_a: assert property (
    (st_q == S_CMD2 && op_q == OP_LOCKDOWN) |-> cyc.wdata[7:0] == CMD_LOCKDN)
    else $error("wrong lock-down code");
  setup_then_code_a: assert property (
    (st_q == S_CMD1 && cyc.ack && op_q inside {OP_LOCK, OP_UNLOCK,
     OP_LOCKDOWN}) |=> st_q == S_CMD2)
    else $error("setup not followed by second code");
  same_block_a: assert property (
    (st_q == S_CMD1) |=> (st_q != S_CMD2) || $stable(cyc.addr))
    else $error("block address moved between pair cycles");
  busy_refuse_a: assert property (
    (st_q != S_IDLE && wr_acc && paddr == REG_CTRL) |=> $stable(op_q))
    else $error("operation replaced while busy");

  lock_done_c: cover property (st_q == S_CMD2 && op_q == OP_LOCKDOWN
                               && cyc.ack);
  poll_retry_c: cover property (st_q == S_SRRD && cyc.ack && !stat_ready);
  seq_err_c: cover property (stat_q[STAT_PFAIL] && stat_q[STAT_EFAIL]);
  lock_viol_c: cover property (stat_q[STAT_LOCKV]);
endmodule

// [test/flash_dev_model.sv]
// behavioural flash device: block lock bits and operation status
`timescale 1ns/10ps
module flash_dev_model
  import flash_lock_pkg::*;
#(
  parameter int BLK_LSB = 15
)
(
  // flash pins
  input  wire logic [ADDR_W-1:0] fl_addr,
  input  wire logic [DQ_W-1:0]   fl_dq_out,
  input  wire logic              fl_ce_n,
  input  wire logic              fl_we_n,
  input  wire logic              fl_oe_n,
  input  wire logic              fl_wp,
  input  wire logic              fl_rst_n,
  output logic [DQ_W-1:0]        fl_dq_in,
  // test control
  input  wire logic              slow,
  input  wire logic [4:0]        inj
);
  logic [7:0]      lock_q  = 8'hFF;
  logic [7:0]      lkdn_q  = 8'h00;
  logic [7:0]      stat_q  = 8'h80;
  logic            setup_q = 1'b0;
  logic [DQ_W-1:0] last_q  = '0;
  int              busy_n  = 0;
  wire  [2:0]      blk     = fl_addr[BLK_LSB +: 3];
  // lock-down only protects while the pin is low
  wire             prot    = lkdn_q[blk] & ~fl_wp;
  wire  [7:0]      eff_lock = lock_q | (lkdn_q & {8{~fl_wp}});
  // reserved bit 0 reads 1 so a host that forgets to mask it is caught
  wire  [DQ_W-1:0] drv = {8'h00, stat_q & {busy_n == 0, 7'h7F} | 8'h01};

  always @(posedge fl_we_n or negedge fl_rst_n)
    if (!fl_rst_n)
    begin
      lock_q  <= 8'hFF;
      lkdn_q  <= 8'h00;
      stat_q  <= 8'h80;
      setup_q <= 1'b0;
    end
    else if (fl_ce_n === 1'b0)
    begin
      busy_n  <= slow ? 3 : 0;
      setup_q <= 1'b0;
      if (setup_q)
        case (fl_dq_out[7:0])
          CMD_LOCK:   if (!prot) lock_q[blk] <= 1'b1;
          CMD_UNLOCK: if (!prot) lock_q[blk] <= 1'b0;
          CMD_LOCKDN:
          begin
            lock_q[blk] <= 1'b1;
            lkdn_q[blk] <= 1'b1;
          end
          default:    stat_q[5:4] <= 2'b11;
        endcase
      else
        case (fl_dq_out[7:0])
          CMD_SETUP:   setup_q <= 1'b1;
          CMD_CLEAR:   stat_q <= stat_q & 8'hC5;
          CMD_RDSTAT:
          begin
            // injected faults stand in for the supply, verify and block lock checks
            stat_q[5:3] <= stat_q[5:3] | inj[3:1];
            stat_q[1]   <= stat_q[1] | inj[0];
          end
          CMD_SUSPEND:
            if (inj[4])
            begin
              stat_q[7] <= 1'b1;
              stat_q[2] <= 1'b1;
            end
            else
              stat_q[7:6] <= 2'b11;
          CMD_RESUME:
          begin
            stat_q[6] <= 1'b0;
            stat_q[2] <= 1'b0;
          end
          default: ;
        endcase
    end

  always @(posedge fl_oe_n)
  begin
    last_q <= drv;
    if (busy_n > 0)
      busy_n <= busy_n - 1;
  end
  // a released bus shows the inverse of the last value, never a kept one
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? drv : ~last_q;
endmodule

// [test/flash_lock_host_tb.sv]
// self-checking bench of the apb flash lock controller
`timescale 1ns/10ps
module flash_lock_host_tb;
  import flash_lock_pkg::*;
  localparam int BLK_LSB = 15;
  logic              pclk = 0;
  logic              presetn = 0;
  logic              psel = 0;
  logic              penable = 0;
  logic              pwrite = 0;
  logic              slow = 0;
  logic [4:0]        inj = '0;
  logic [7:0]        paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [ADDR_W-1:0] fl_addr;
  logic [DQ_W-1:0]   fl_dq_in;
  logic [DQ_W-1:0]   fl_dq_out;
  logic              fl_dq_oe_n;
  logic              fl_ce_n;
  logic              fl_we_n;
  logic              fl_oe_n;
  logic              fl_wp;
  logic              fl_rst_n;
  logic [31:0]       rd;
  logic              er;
  int                n_fail = 0;
  int                total_checks = 0;

  flash_lock_host dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out),
    .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n), .fl_wp(fl_wp), .fl_rst_n(fl_rst_n));

  flash_dev_model #(.BLK_LSB(BLK_LSB)) fm (.fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n), .fl_wp(fl_wp), .fl_rst_n(fl_rst_n),
    .fl_dq_in(fl_dq_in), .slow(slow), .inj(inj));

  initial
  begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic st(input logic [31:0] exp);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", exp, rd);
  endtask

  task automatic wait_idle;
    int i;
    i = 0;
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      i++;
    end
    while (rd[ST_BUSY] !== 1'b0 && i < 200);
    chk("busy", 32'h0, {31'h0, rd[ST_BUSY]});
  endtask

  task automatic op(input op_t o, input int b);
    apb(1'b1, REG_ADDR, 32'(b << BLK_LSB));
    apb(1'b1, REG_CTRL, 32'(o));
    wait_idle();
  endtask

  task automatic pins(input logic [31:0] v);
    apb(1'b1, REG_PINS, v);
    repeat (2) @(posedge pclk);
  endtask

  task automatic cl(input int b, input logic e);
    chk("block lock", {31'h0, e}, {31'h0, fm.eff_lock[b]});
  endtask

  task automatic t_reset;
    apb(1'b0, REG_PINS, 32'h0);
    chk("pins", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    chk("all locked", 32'hFF, {24'h0, fm.eff_lock});
    $display("test reset done");
  endtask

  task automatic t_lock;
    op(OP_UNLOCK, 2);
    cl(2, 1'b0);
    st(32'h80);
    op(OP_LOCK, 2);
    cl(2, 1'b1);
    cl(3, 1'b1);
    apb(1'b0, REG_ADDR, 32'h0);
    chk("block addr", 32'(2 << BLK_LSB), rd);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("last op", 32'(OP_LOCK), rd);
    $display("test lock done");
  endtask

  task automatic t_lockdown;
    op(OP_UNLOCK, 4);
    op(OP_LOCKDOWN, 4);
    cl(4, 1'b1);
    op(OP_UNLOCK, 4);
    cl(4, 1'b1);
    pins(32'h1);
    chk("wp pin", 32'h1, {31'h0, fl_wp});
    op(OP_UNLOCK, 4);
    cl(4, 1'b0);
    op(OP_LOCK, 4);
    cl(4, 1'b1);
    op(OP_UNLOCK, 4);
    pins(32'h0);
    cl(4, 1'b1);
    $display("test lockdown done");
  endtask

  task automatic t_status;
    op(OP_BADSEQ, 1);
    st(32'h2B0);
    op(OP_CLEAR, 1);
    st(32'h80);
    op(OP_SUSPEND, 0);
    st(32'h40C0);
    op(OP_RESUME, 0);
    op(OP_READ, 0);
    st(32'h80);
    inj <= 5'h10;
    op(OP_SUSPEND, 0);
    st(32'h4084);
    inj <= 5'h00;
    op(OP_RESUME, 0);
    op(OP_READ, 0);
    st(32'h80);
    $display("test status done");
  endtask

  task automatic t_fault;
    inj <= 5'h04;
    op(OP_READ, 0);
    st(32'h890);
    inj <= 5'h00;
    op(OP_CLEAR, 0);
    inj <= 5'h0B;
    op(OP_READ, 0);
    st(32'h34AA);
    inj <= 5'h00;
    op(OP_CLEAR, 0);
    st(32'h80);
    $display("test fault done");
  endtask

  task automatic t_slow;
    slow <= 1'b1;
    apb(1'b1, REG_ADDR, 32'(5 << BLK_LSB));
    apb(1'b1, REG_CTRL, 32'(OP_UNLOCK));
    apb(1'b0, REG_STATUS, 32'h0);
    chk("busy set", 32'h1, {31'h0, rd[ST_BUSY]});
    // a command written while busy must be dropped
    apb(1'b1, REG_CTRL, 32'(OP_LOCK));
    wait_idle();
    cl(5, 1'b0);
    st(32'h80);
    slow <= 1'b0;
    $display("test slow done");
  endtask

  task automatic t_rstpin;
    op(OP_LOCKDOWN, 6);
    pins(32'h2);
    chk("reset pin", 32'h0, {31'h0, fl_rst_n});
    pins(32'h0);
    chk("locked after reset", 32'hFF, {24'h0, fm.eff_lock});
    chk("lockdown cleared", 32'h0, {24'h0, fm.lkdn_q});
    $display("test reset pin done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_lock();
    t_lockdown();
    t_status();
    t_fault();
    t_slow();
    t_rstpin();
    close_out();
  end

  initial
  begin
    #400us;
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    close_out();
  end
endmodule
